// ===== verilog/timer_pkg.sv
`default_nettype none
package timer_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_CC = 3;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_COUNT = 5'h04;
  localparam logic [4:0] OFS_CCTL0 = 5'h08;
  localparam logic [4:0] OFS_CC_STRIDE = 5'h08;
  localparam logic [4:0] OFS_CCR_DELTA = 5'h04;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLR_BIT = 2;
  localparam int CTRL_DIV_LSB = 3;
  localparam int CTRL_ROLL_BIT = 8;

  // ----------------------------------------
  // capture/compare control fields
  // ----------------------------------------
  localparam int CC_CAP_BIT = 0;
  localparam int CC_SEL_LSB = 1;
  localparam int CC_EDGE_LSB = 3;
  localparam int CC_SYNC_BIT = 5;
  localparam int CC_FLAG_BIT = 6;
  localparam int CC_OVR_BIT = 7;
  localparam int CC_LVL_BIT = 8;
  localparam int CC_SAMPLED_INPUT_LEVEL_BIT = 9;

  // ----------------------------------------
  // values
  // ----------------------------------------
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [1:0] BE_LOW_HALF = 2'h3;
  localparam logic [2:0] DIV_ZERO = 3'h0;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_UP = 2'b01,
    MODE_CONT = 2'b10,
    MODE_UPDN = 2'b11
  } count_mode_e;

endpackage : timer_pkg
`default_nettype wire

// ===== verilog/capcomp_unit.sv
`timescale 1ns/1ps
`default_nettype none
module capcomp_unit
  import timer_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic capture_source_a_i,
  input wire logic capture_source_b_i,
  input wire logic ctl_we_i,
  input wire logic ccr_we_i,
  input wire logic ccr_re_i,
  input wire logic [15:0] wdata_i,
  input wire logic tclk_i,
  input wire logic step_i,
  input wire logic [15:0] count_i,
  input wire logic [15:0] count_next_i,
  output logic [15:0] ctl_o,
  output logic [15:0] ccr_o,
  output logic match_o
);

  logic capture_select_q, sync_capture_q, lvl_q, pend_q;
  logic [1:0] capture_input_sel_q, capture_edge_sel_q;
  logic capcomp_flag_q, capture_overrun_q, unread_q;
  logic sampled_input_level_q, compare_match_q;
  logic [15:0] capcomp_reg_q;
  logic sel_lvl, rise, fall, hit, cap_ev, cmp_ev;

  // ----------------------------------------
  // input select and edge detect
  // ----------------------------------------
  // high select bit forces a constant level from the low bit
  assign sel_lvl = capture_input_sel_q[1] ? capture_input_sel_q[0] :
                   (capture_input_sel_q[0] ? capture_source_b_i : capture_source_a_i);
  assign rise = sel_lvl & ~lvl_q;
  assign fall = ~sel_lvl & lvl_q;
  assign hit = capture_select_q & ((capture_edge_sel_q[0] & rise) |
                                   (capture_edge_sel_q[1] & fall));
  // synced capture waits for the next timer clock
  assign cap_ev = sync_capture_q ? (tclk_i & (pend_q | hit)) : hit;
  // compare fires only when the counter counts into the value
  assign cmp_ev = ~capture_select_q & step_i & (count_next_i == capcomp_reg_q);

  // control fields, level history and pending capture
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capture_select_q <= 1'b0;
      capture_input_sel_q <= 2'b00;
      capture_edge_sel_q <= 2'b00;
      sync_capture_q <= 1'b0;
      lvl_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      lvl_q <= sel_lvl;
      pend_q <= cap_ev ? 1'b0 : (pend_q | hit);
      if (ctl_we_i) begin
        capture_select_q <= wdata_i[CC_CAP_BIT];
        capture_input_sel_q <= wdata_i[CC_SEL_LSB +: 2];
        capture_edge_sel_q <= wdata_i[CC_EDGE_LSB +: 2];
        sync_capture_q <= wdata_i[CC_SYNC_BIT];
      end
    end
  end

  // register value: capture beats a software write
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capcomp_reg_q <= CNT_ZERO;
    end else if (cap_ev) begin
      capcomp_reg_q <= count_i;
    end else if (ccr_we_i) begin
      capcomp_reg_q <= wdata_i[15:0];
    end
  end

  // flags: hardware set wins over write-one-to-clear
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capcomp_flag_q <= 1'b0;
      capture_overrun_q <= 1'b0;
      unread_q <= 1'b0;
      sampled_input_level_q <= 1'b0;
      compare_match_q <= 1'b0;
    end else begin
      compare_match_q <= cmp_ev;
      if (cap_ev | cmp_ev) begin
        capcomp_flag_q <= 1'b1;
      end else if (ctl_we_i && wdata_i[CC_FLAG_BIT]) begin
        capcomp_flag_q <= 1'b0;
      end
      if (cap_ev && unread_q) begin
        capture_overrun_q <= 1'b1;
      end else if (ctl_we_i && wdata_i[CC_OVR_BIT]) begin
        capture_overrun_q <= 1'b0;
      end
      if (cap_ev) begin
        unread_q <= 1'b1;
      end else if (ccr_re_i) begin
        unread_q <= 1'b0;
      end
      if (cmp_ev) begin
        sampled_input_level_q <= sel_lvl;
      end
    end
  end

  assign ccr_o = capcomp_reg_q;
  assign match_o = compare_match_q;
  // readback; level bit shows the selected input
  always_comb begin
    ctl_o = CNT_ZERO;
    ctl_o[CC_CAP_BIT] = capture_select_q;
    ctl_o[CC_SEL_LSB +: 2] = capture_input_sel_q;
    ctl_o[CC_EDGE_LSB +: 2] = capture_edge_sel_q;
    ctl_o[CC_SYNC_BIT] = sync_capture_q;
    ctl_o[CC_FLAG_BIT] = capcomp_flag_q;
    ctl_o[CC_OVR_BIT] = capture_overrun_q;
    ctl_o[CC_LVL_BIT] = lvl_q;
    ctl_o[CC_SAMPLED_INPUT_LEVEL_BIT] = sampled_input_level_q;
  end

  property p_capture;
    @(posedge mclk_i) disable iff (!resetn_i)
      cap_ev |=> (capcomp_reg_q == $past(count_i)) && capcomp_flag_q;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not latch count and flag");

  property p_overrun;
    @(posedge mclk_i) disable iff (!resetn_i)
      (cap_ev && unread_q) |=> capture_overrun_q;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("second capture without read left overrun clear");

endmodule : capcomp_unit
`default_nettype wire

// ===== verilog/timer_top.sv
// Functional notes
// - counter advances only with nonzero mode and a running timer clock
// - zero period in up modes stops; nonzero write restarts upward from zero
// - mode 00 halt, 01 up, 10 continuous, 11 up/down
// - up mode wraps to zero after the period value
// - up mode with count above period restarts from zero
// - up mode sets block zero flag at period, rollover on wrap
// - period rewrite in up mode: count to it or roll over
// - continuous wraps at ffff and sets rollover; block zero is ordinary
// - up/down climbs to period then falls to zero
// - direction latched; clear resets direction, count and divider
// - up/down flags once per period: at period and at one-to-zero
// - rewrite while descending keeps descending; shadow loads at once
// - rewrite while ascending: climb to it or start descending
// - capture/compare registers are written without buffering
// - three identical capture/compare blocks
// - capture mode picks source and edge per select fields
// - capture copies count and sets the block flag
// - selected input level readable at any time
// - sync bit aligns capture to the next timer clock
// - overrun set on capture before prior value read; software clears
// - constant level select lets software toggle trigger captures
// - compare match sets flag, pulses match, samples input level
// - direct counter writes trigger no flag or match
// - counter steps once per divided timer clock
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module timer_top
  import timer_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic timer_tick_i,
  input wire logic [NUM_CC-1:0] capture_source_a_i,
  input wire logic [NUM_CC-1:0] capture_source_b_i,
  output logic [NUM_CC-1:0] compare_match_o,
  output logic rollover_flag_o
);

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic [15:0] rmux;
  logic acc, wr, rd;
  logic [15:0] wdata;

  // one wait cycle: the request is taken while wait is low
  assign acc = (avs_read_i | avs_write_i) & ~wait_q;
  assign wr = acc & avs_write_i & (avs_byteenable_i[1:0] == BE_LOW_HALF);
  assign rd = acc & avs_read_i;
  assign wdata = avs_writedata_i[15:0];

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
    end
  end

  // read data captured as wait drops, held while it is low
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= {16'h0000, rmux};
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  count_mode_e count_mode_sel_q;
  logic [1:0] div_sel_q;
  logic rollover_flag_q;
  logic ctrl_we, counter_clear, cnt_we;
  logic step, adv, roll_ev;

  assign ctrl_we = wr && (avs_address_i == OFS_CTRL);
  assign cnt_we = wr && (avs_address_i == OFS_COUNT);
  // clear is a self-clearing strobe, reads back as zero
  assign counter_clear = ctrl_we && wdata[CTRL_CLR_BIT];

  // mode and divider selection
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_mode_sel_q <= MODE_STOP;
      div_sel_q <= 2'b00;
    end else if (ctrl_we) begin
      count_mode_sel_q <= count_mode_e'(wdata[CTRL_MODE_LSB +: 2]);
      div_sel_q <= wdata[CTRL_DIV_LSB +: 2];
    end
  end

  // rollover flag: set wins over write-one-to-clear
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rollover_flag_q <= 1'b0;
    end else if (roll_ev) begin
      rollover_flag_q <= 1'b1;
    end else if (ctrl_we && wdata[CTRL_ROLL_BIT]) begin
      rollover_flag_q <= 1'b0;
    end
  end

  assign rollover_flag_o = rollover_flag_q;

  // ----------------------------------------
  // clock divider
  // ----------------------------------------
  logic [2:0] div_q, div_mask;
  logic div_tick;

  assign div_mask = 3'((4'h1 << div_sel_q) - 4'h1);
  assign div_tick = timer_tick_i && ((div_q & div_mask) == div_mask);

  // divider counts source ticks; clear restarts it
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= DIV_ZERO;
    end else if (counter_clear) begin
      div_q <= DIV_ZERO;
    end else if (timer_tick_i) begin
      div_q <= div_q + 3'h1;
    end
  end

  // ----------------------------------------
  // counter core
  // ----------------------------------------
  logic [15:0] counter_value_q, cnt_d;
  logic [15:0] period_shadow_latch_q;
  logic dir_down_q, dir_d;
  logic up_modes, per_zero, ccr0_we, restart;
  logic [NUM_CC-1:0] cctl_we, ccr_we, ccr_re;
  logic [15:0] cctl_rd [NUM_CC];
  logic [15:0] ccr_rd [NUM_CC];

  assign up_modes = (count_mode_sel_q == MODE_UP) || (count_mode_sel_q == MODE_UPDN);
  assign per_zero = (period_shadow_latch_q == CNT_ZERO);
  assign ccr0_we = ccr_we[0];
  // writing the period in up modes restarts from zero when it was or becomes zero
  assign restart = ccr0_we && up_modes && (per_zero || (wdata == CNT_ZERO));
  // step on the divided clock with a nonzero mode and, in up modes, a nonzero period
  assign step = div_tick && (count_mode_sel_q != MODE_STOP) &&
                !(up_modes && per_zero);
  // a step that really counts: clear, direct write and restart take it over
  assign adv = step && !counter_clear && !cnt_we && !restart;
  assign roll_ev = adv && (cnt_d == CNT_ZERO) && (counter_value_q != CNT_ZERO);

  // next count and direction for each mode
  always_comb begin
    cnt_d = counter_value_q;
    dir_d = dir_down_q;
    unique case (count_mode_sel_q)
      MODE_STOP: begin
        cnt_d = counter_value_q;
      end
      MODE_UP: begin
        // at or above the period the count wraps to zero
        if (counter_value_q >= period_shadow_latch_q) begin
          cnt_d = CNT_ZERO;
        end else begin
          cnt_d = counter_value_q + CNT_ONE;
        end
      end
      MODE_CONT: begin
        if (counter_value_q == CNT_MAX) begin
          cnt_d = CNT_ZERO;
        end else begin
          cnt_d = counter_value_q + CNT_ONE;
        end
      end
      MODE_UPDN: begin
        if (!dir_down_q) begin
          // climbing: turn at or above the period
          if (counter_value_q >= period_shadow_latch_q) begin
            dir_d = 1'b1;
            cnt_d = counter_value_q - CNT_ONE;
          end else begin
            cnt_d = counter_value_q + CNT_ONE;
          end
        end else if (counter_value_q == CNT_ZERO) begin
          dir_d = 1'b0;
          cnt_d = CNT_ONE;
        end else begin
          // descent ignores the period until zero is reached
          cnt_d = counter_value_q - CNT_ONE;
          if (counter_value_q == CNT_ONE) begin
            dir_d = 1'b0;
          end
        end
      end
    endcase
  end

  // counter value: clear, then direct write, then restart, then step
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      counter_value_q <= CNT_ZERO;
    end else if (counter_clear) begin
      counter_value_q <= CNT_ZERO;
    end else if (cnt_we) begin
      counter_value_q <= wdata;
    end else if (restart) begin
      counter_value_q <= CNT_ZERO;
    end else if (step) begin
      counter_value_q <= cnt_d;
    end
  end

  // direction latch survives stop; clear or restart sets upward
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir_down_q <= 1'b0;
    end else if (counter_clear || restart) begin
      dir_down_q <= 1'b0;
    end else if (adv) begin
      dir_down_q <= dir_d;
    end
  end

  // period shadow follows each period write at once
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      period_shadow_latch_q <= CNT_ZERO;
    end else if (ccr0_we) begin
      period_shadow_latch_q <= wdata;
    end
  end

  // ----------------------------------------
  // capture/compare blocks
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CC; gi++) begin : g_cc
      localparam logic [4:0] CTL_OFS = 5'(OFS_CCTL0 + 5'(gi) * OFS_CC_STRIDE);
      localparam logic [4:0] CCR_OFS = 5'(CTL_OFS + OFS_CCR_DELTA);
      assign cctl_we[gi] = wr && (avs_address_i == CTL_OFS);
      assign ccr_we[gi] = wr && (avs_address_i == CCR_OFS);
      assign ccr_re[gi] = rd && (avs_address_i == CCR_OFS);
      // identical blocks share the counter and step
      capcomp_unit u_cc (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .capture_source_a_i(capture_source_a_i[gi]),
        .capture_source_b_i(capture_source_b_i[gi]),
        .ctl_we_i(cctl_we[gi]),
        .ccr_we_i(ccr_we[gi]),
        .ccr_re_i(ccr_re[gi]),
        .wdata_i(wdata),
        .tclk_i(div_tick),
        .step_i(adv),
        .count_i(counter_value_q),
        .count_next_i(cnt_d),
        .ctl_o(cctl_rd[gi]),
        .ccr_o(ccr_rd[gi]),
        .match_o(compare_match_o[gi])
      );
    end
  endgenerate

  // read mux; unmapped offsets read zero
  always_comb begin
    rmux = CNT_ZERO;
    if (avs_address_i == OFS_CTRL) begin
      rmux[CTRL_MODE_LSB +: 2] = count_mode_sel_q;
      rmux[CTRL_DIV_LSB +: 2] = div_sel_q;
      rmux[CTRL_ROLL_BIT] = rollover_flag_q;
    end
    if (avs_address_i == OFS_COUNT) begin
      rmux = counter_value_q;
    end
    for (int n = 0; n < NUM_CC; n++) begin
      if (avs_address_i == 5'(OFS_CCTL0 + 5'(n) * OFS_CC_STRIDE)) begin
        rmux = cctl_rd[n];
      end
      if (avs_address_i == 5'(OFS_CCTL0 + 5'(n) * OFS_CC_STRIDE + OFS_CCR_DELTA)) begin
        rmux = ccr_rd[n];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_halt;
    @(posedge mclk_i) disable iff (!resetn_i)
      (count_mode_sel_q == MODE_STOP && !cnt_we && !counter_clear && !restart)
      |=> $stable(counter_value_q) && $stable(dir_down_q);
  endproperty
  a_halt: assert property (p_halt)
    else $error("counter moved while halted");

  property p_zero_period;
    @(posedge mclk_i) disable iff (!resetn_i)
      (up_modes && per_zero) |-> !step;
  endproperty
  a_zero_period: assert property (p_zero_period)
    else $error("counter stepped with zero period");

  property p_up_wrap;
    @(posedge mclk_i) disable iff (!resetn_i)
      (step && count_mode_sel_q == MODE_UP && counter_value_q >= period_shadow_latch_q
       && !cnt_we && !counter_clear) |=> (counter_value_q == CNT_ZERO);
  endproperty
  a_up_wrap: assert property (p_up_wrap)
    else $error("up mode did not wrap at period");

  property p_cont_wrap;
    @(posedge mclk_i) disable iff (!resetn_i)
      (step && count_mode_sel_q == MODE_CONT && counter_value_q == CNT_MAX
       && !cnt_we && !counter_clear) |=> (counter_value_q == CNT_ZERO) && rollover_flag_q;
  endproperty
  a_cont_wrap: assert property (p_cont_wrap)
    else $error("continuous wrap missed or no rollover flag");

  property p_ud_turn;
    @(posedge mclk_i) disable iff (!resetn_i)
      (step && count_mode_sel_q == MODE_UPDN && !dir_down_q
       && counter_value_q >= period_shadow_latch_q && !counter_clear && !restart)
      |=> dir_down_q;
  endproperty
  a_ud_turn: assert property (p_ud_turn)
    else $error("up/down did not turn at period");

  property p_ud_descend;
    @(posedge mclk_i) disable iff (!resetn_i)
      (step && count_mode_sel_q == MODE_UPDN && dir_down_q && counter_value_q != CNT_ZERO
       && !cnt_we && !counter_clear && !restart)
      |=> (counter_value_q == $past(counter_value_q) - CNT_ONE);
  endproperty
  a_ud_descend: assert property (p_ud_descend)
    else $error("descent did not continue");

  property p_clear;
    @(posedge mclk_i) disable iff (!resetn_i)
      counter_clear |=> (counter_value_q == CNT_ZERO) && !dir_down_q && (div_q == DIV_ZERO);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left count, direction or divider");

  property p_direct_write;
    @(posedge mclk_i) disable iff (!resetn_i)
      (cnt_we && !counter_clear) |=> !rollover_flag_q || $past(rollover_flag_q);
  endproperty
  a_direct_write: assert property (p_direct_write)
    else $error("direct counter write raised rollover");

  property p_rollover;
    @(posedge mclk_i) disable iff (!resetn_i)
      roll_ev |=> rollover_flag_q && (counter_value_q == CNT_ZERO);
  endproperty
  a_rollover: assert property (p_rollover)
    else $error("rollover flag not set on wrap to zero");

  property p_wait;
    @(posedge mclk_i) disable iff (!resetn_i)
      ((avs_read_i || avs_write_i) && wait_q) |=> !wait_q ##1 wait_q;
  endproperty
  a_wait: assert property (p_wait)
    else $error("waitrequest not low for one cycle");

endmodule : timer_top
`default_nettype wire

// ===== tb/test_timer_count_modes_capcomp.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer_count_modes_capcomp
  import timer_pkg::*;
;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [DATA_W-1:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [DATA_W-1:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic timer_tick_i = 1'b0;
  logic [NUM_CC-1:0] capture_source_a_i = '0;
  logic [NUM_CC-1:0] capture_source_b_i = '0;
  logic [NUM_CC-1:0] compare_match_o;
  logic rollover_flag_o;
  logic [NUM_CC-1:0] seen_q = '0;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 32'hbcbbeb1b;
  logic [15:0] rv;

  // ----------------------------------------
  // clock and design
  // ----------------------------------------
  always #20 mclk_i = ~mclk_i;

  timer_top i_timer_top (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .timer_tick_i(timer_tick_i),
    .capture_source_a_i(capture_source_a_i), .capture_source_b_i(capture_source_b_i),
    .compare_match_o(compare_match_o), .rollover_flag_o(rollover_flag_o)
  );

  // ----------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    n_compared++;
    if ((got & m) !== (e & m)) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got & m, e & m);
    end
  endtask : cmp

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // hold the request until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                     input logic [3:0] be);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {16'h0000, d};
    avs_byteenable_i <= be;
    @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : acc

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask : wr

  // note the expected read value, then issue the read
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back({16'h0000, e});
    mask_q.push_back({16'h0000, m});
    acc(1'b0, a, 16'h0000, 4'hf);
  endtask : rd

  // single-cycle timer ticks, then let flags settle
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      timer_tick_i <= 1'b1;
      @(posedge mclk_i);
      timer_tick_i <= 1'b0;
    end
    repeat (3) @(posedge mclk_i);
  endtask : pulse

  task automatic chk_match(input logic [2:0] e);
    cmp({29'h0, seen_q}, {29'h0, e}, 32'h7);
    @(posedge mclk_i);
    seen_q <= '0;
  endtask : chk_match

  // ----------------------------------------
  // monitor: read results, match pulses, timeout
  // ----------------------------------------
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (|compare_match_o) seen_q <= seen_q | compare_match_o;
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) cmp(avs_readdata_o, 32'h0, 32'h0);
      else cmp(avs_readdata_o, exp_q.pop_front(), mask_q.pop_front());
    end
    if (cycles > 5000) begin
      error_cnt++;
      test_done();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rv = $random(seed);
    wr(5'h04, 16'h0000);
    wr(5'h04, 16'h0005);
    acc(1'b1, 5'h04, 16'h0009, 4'h0);
    pulse(3);
    rd(5'h04, 16'h0005, 16'hffff);
    rd(5'h00, 16'h0000, 16'hffff);
    chk_match(3'b000);
    $display("stop mode done");
    wr(5'h0c, 16'h0003);
    wr(5'h04, 16'h0000);
    wr(5'h00, 16'h0001);
    pulse(4);
    rd(5'h04, 16'h0000, 16'hffff);
    rd(5'h00, 16'h0101, 16'hffff);
    rd(5'h08, 16'h0040, 16'h0040);
    chk_match(3'b111);
    wr(5'h04, 16'h0009);
    pulse(1);
    rd(5'h04, 16'h0000, 16'hffff);
    wr(5'h0c, 16'h0000);
    pulse(2);
    rd(5'h04, 16'h0000, 16'hffff);
    wr(5'h0c, 16'h0003);
    pulse(2);
    rd(5'h04, 16'h0002, 16'hffff);
    $display("up mode done");
    wr(5'h00, 16'h0102);
    wr(5'h04, 16'hffff);
    pulse(1);
    rd(5'h04, 16'h0000, 16'hffff);
    rd(5'h00, 16'h0102, 16'hffff);
    $display("continuous mode done");
    wr(5'h00, 16'h0104);
    wr(5'h0c, 16'h0002);
    wr(5'h00, 16'h0003);
    pulse(3);
    rd(5'h04, 16'h0001, 16'hffff);
    wr(5'h00, 16'h0000);
    pulse(2);
    wr(5'h00, 16'h0003);
    pulse(1);
    rd(5'h04, 16'h0000, 16'hffff);
    rd(5'h00, 16'h0103, 16'hffff);
    pulse(3);
    wr(5'h00, 16'h0007);
    pulse(1);
    rd(5'h04, 16'h0001, 16'hffff);
    chk_match(3'b111);
    $display("up/down mode done");
    wr(5'h00, 16'h0104);
    wr(5'h04, rv);
    wr(5'h10, 16'h0006);
    wr(5'h10, 16'h001f);
    wr(5'h10, 16'h001d);
    rd(5'h14, rv, 16'hffff);
    wr(5'h10, 16'h001f);
    wr(5'h10, 16'h001d);
    rd(5'h10, 16'h00c0, 16'h01c0);
    wr(5'h10, 16'h00db);
    rd(5'h10, 16'h0000, 16'h00c0);
    wr(5'h04, 16'h0123);
    wr(5'h08, 16'h0009);
    @(posedge mclk_i);
    capture_source_a_i <= 3'b001;
    repeat (3) @(posedge mclk_i);
    rd(5'h0c, 16'h0123, 16'hffff);
    rd(5'h08, 16'h0140, 16'h0140);
    // synced capture: the edge waits for the next timer tick
    wr(5'h10, 16'h003d);
    wr(5'h10, 16'h003f);
    wr(5'h04, 16'h0077);
    pulse(1);
    rd(5'h14, 16'h0077, 16'hffff);
    $display("capture done");
    wr(5'h18, 16'h0006);
    wr(5'h1c, 16'h0005);
    wr(5'h04, 16'h0003);
    wr(5'h00, 16'h0002);
    pulse(2);
    chk_match(3'b100);
    rd(5'h18, 16'h0240, 16'h0240);
    $display("compare done");
    test_done();
  end
endmodule : test_timer_count_modes_capcomp
`default_nettype wire
